// >>> logic/sdch_pkg.sv
// Purpose: shared types and constants for the subframe dynamic configuration handler
// Assumes: one clock domain, DMA queues modelled as valid/ready streams
// Notes: configuration word widths are plain defaults
package sdch_pkg;
	localparam int unsigned SUBFRAME_W = 4;
	localparam int unsigned FRAME_W = 10;
	localparam int unsigned CFG_W = 64;
	localparam logic [SUBFRAME_W-1:0] LAST_SUBFRAME = 4'h9;
	localparam logic STRICT_RESET = 1'b0;
	localparam logic [CFG_W-1:0] EMPTY_CFG = 64'h0000000000000000;

	typedef struct packed {
		logic [FRAME_W-1:0] frame;
		logic [SUBFRAME_W-1:0] subframe;
	} timing_notice_t;

	typedef struct packed {
		logic valid;
		logic stale;
		logic [CFG_W-1:0] cfg;
	} encoder_cfg_t;
endpackage

// >>> logic/subframe_dynamic_config_handler.sv
// Purpose: posts per-subframe timing notices and hands host configurations to the encoders
// Assumes: trigger is a one-cycle pulse from logic on clk; queues use valid/ready
// Notes:
// Notes on behaviour
// - each trigger pushes a timing notice describing the following subframe
// - at the next trigger the queued configuration goes to the encoders
// - strict mode with nothing queued supplies an empty configuration
// - tolerant mode with nothing queued resupplies the last received configuration
// - strict mode comes up off after reset
`timescale 1ns/1ps
`default_nettype none
module subframe_dynamic_config_handler (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Mode control
	input wire logic strict_timing_mode_set,
	input wire logic strict_timing_mode_val,
	// Subframe trigger
	input wire logic subframe_trigger,
	// Timing notice queue, target to host
	output sdch_pkg::timing_notice_t timing_notice_data,
	output logic timing_notice_valid,
	input wire logic timing_notice_ready,
	output logic timing_notice_overflow,
	// Downlink configuration queue, host to target
	input wire logic [sdch_pkg::CFG_W-1:0] downlink_config_data,
	input wire logic downlink_config_valid,
	output logic downlink_config_ready,
	// Encoder side
	output sdch_pkg::encoder_cfg_t encoder_cfg,
	output logic encoder_cfg_strobe,
	output logic strict_timing_mode
);
	// Registered state, one register per concern
	logic strict_ff;
	logic [sdch_pkg::SUBFRAME_W-1:0] sf_ff;
	logic [sdch_pkg::FRAME_W-1:0] fr_ff;
	sdch_pkg::timing_notice_t notice_ff;
	logic notice_vld_ff;
	logic ovf_ff;
	logic cfg_rdy_ff;
	logic [sdch_pkg::CFG_W-1:0] held_ff;
	sdch_pkg::encoder_cfg_t enc_ff;
	logic enc_stb_ff;
	// Next values of the registers above
	logic nxt_strict;
	sdch_pkg::timing_notice_t nxt_pos;
	sdch_pkg::timing_notice_t nxt_notice;
	logic nxt_notice_vld;
	logic [sdch_pkg::CFG_W-1:0] nxt_held;
	sdch_pkg::encoder_cfg_t nxt_enc;
	// Handshake terms
	logic take_cfg;
	logic notice_taken;
	logic notice_lost;

	// Subframe after the given one; the frame number wraps silently at its width
	function automatic sdch_pkg::timing_notice_t step_position(
		input logic [sdch_pkg::FRAME_W-1:0] frame,
		input logic [sdch_pkg::SUBFRAME_W-1:0] subframe
	);
		sdch_pkg::timing_notice_t pos;
		if (subframe == sdch_pkg::LAST_SUBFRAME) begin
			pos.frame = frame + 1'b1;
			pos.subframe = '0;
		end else begin
			pos.frame = frame;
			pos.subframe = subframe + 1'b1;
		end
		return pos;
	endfunction

	// Fresh word first; otherwise the mode picks between empty and the last word
	function automatic sdch_pkg::encoder_cfg_t pick_cfg(
		input logic fresh,
		input logic strict,
		input logic [sdch_pkg::CFG_W-1:0] word,
		input logic [sdch_pkg::CFG_W-1:0] last
	);
		sdch_pkg::encoder_cfg_t sel;
		if (fresh) begin
			sel.valid = 1'b1;
			sel.stale = 1'b0;
			sel.cfg = word;
		end else if (strict) begin
			sel.valid = 1'b0;
			sel.stale = 1'b0;
			sel.cfg = sdch_pkg::EMPTY_CFG;
		end else begin
			sel.valid = 1'b1;
			sel.stale = 1'b1;
			sel.cfg = last;
		end
		return sel;
	endfunction

	assign nxt_pos = step_position(fr_ff, sf_ff);
	// A word is taken only in a trigger cycle, so early words wait in the host queue
	assign take_cfg = subframe_trigger && downlink_config_valid && cfg_rdy_ff;
	assign notice_taken = notice_vld_ff && timing_notice_ready;
	// An untaken notice is overwritten rather than queued; the pulse tells the host
	assign notice_lost = subframe_trigger && notice_vld_ff && !timing_notice_ready;

	always_comb begin
		nxt_strict = strict_ff;
		if (strict_timing_mode_set) begin
			nxt_strict = strict_timing_mode_val;
		end
	end

	always_comb begin
		nxt_notice = notice_ff;
		if (subframe_trigger) begin
			nxt_notice = nxt_pos;
		end
	end

	// A new notice wins over the host taking the old one in the same cycle
	always_comb begin
		nxt_notice_vld = notice_vld_ff;
		if (subframe_trigger) begin
			nxt_notice_vld = 1'b1;
		end else if (notice_taken) begin
			nxt_notice_vld = 1'b0;
		end
	end

	always_comb begin
		nxt_held = held_ff;
		if (take_cfg) begin
			nxt_held = downlink_config_data;
		end
	end

	always_comb begin
		nxt_enc = enc_ff;
		if (subframe_trigger) begin
			nxt_enc = pick_cfg(take_cfg, strict_ff, downlink_config_data, held_ff);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strict_ff <= sdch_pkg::STRICT_RESET;
		end else begin
			strict_ff <= nxt_strict;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sf_ff <= '0;
		end else if (subframe_trigger) begin
			sf_ff <= nxt_pos.subframe;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fr_ff <= '0;
		end else if (subframe_trigger) begin
			fr_ff <= nxt_pos.frame;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			notice_ff <= '0;
		end else begin
			notice_ff <= nxt_notice;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			notice_vld_ff <= 1'b0;
		end else begin
			notice_vld_ff <= nxt_notice_vld;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_ff <= 1'b0;
		end else begin
			ovf_ff <= notice_lost;
		end
	end

	// Ready is registered high so the trigger alone gates acceptance
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_rdy_ff <= 1'b0;
		end else begin
			cfg_rdy_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held_ff <= sdch_pkg::EMPTY_CFG;
		end else begin
			held_ff <= nxt_held;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enc_ff <= '0;
		end else begin
			enc_ff <= nxt_enc;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enc_stb_ff <= 1'b0;
		end else begin
			enc_stb_ff <= subframe_trigger;
		end
	end

	assign timing_notice_data = notice_ff;
	assign timing_notice_valid = notice_vld_ff;
	assign timing_notice_overflow = ovf_ff;
	assign downlink_config_ready = cfg_rdy_ff && subframe_trigger;
	assign encoder_cfg = enc_ff;
	assign encoder_cfg_strobe = enc_stb_ff;
	assign strict_timing_mode = strict_ff;
endmodule
`default_nettype wire

// >>> verif/sdch_chk_sva.sv
// Purpose: concurrent checks on the handler's ports
// Assumes: one clock, asynchronous active-low reset
// Notes: held configuration values are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module sdch_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Mode and trigger
	input wire logic strict_timing_mode_set,
	input wire logic strict_timing_mode,
	input wire logic subframe_trigger,
	// Timing notice queue
	input wire logic timing_notice_valid,
	input wire logic timing_notice_overflow,
	// Configuration queue and encoder side
	input wire logic [sdch_pkg::CFG_W-1:0] downlink_config_data,
	input wire logic downlink_config_valid,
	input wire logic downlink_config_ready,
	input wire sdch_pkg::encoder_cfg_t encoder_cfg,
	input wire logic encoder_cfg_strobe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Ready may rise on an empty queue, so a take needs valid too
	wire logic tk = downlink_config_ready && downlink_config_valid;
	wire logic mt = subframe_trigger && !tk;
	note_post_a: assert property (subframe_trigger |=> timing_notice_valid)
		else $error("notice missing");
	ovf_keep_a: assert property (timing_notice_overflow |-> timing_notice_valid)
		else $error("overflow without a pending notice");
	cfg_fwd_a: assert property (tk |=> encoder_cfg == {2'b10, $past(downlink_config_data)})
		else $error("config not forwarded");
	strict_empty_a: assert property (mt && strict_timing_mode |=> encoder_cfg == '0)
		else $error("config not empty");
	stale_resupply_a: assert property (mt && !strict_timing_mode |=> encoder_cfg[65:64] == 2'b11)
		else $error("config not resupplied");
	mode_reset_a: assert property ($rose(arst_n) |-> !strict_timing_mode)
		else $error("strict mode after reset");
	mode_hold_a: assert property (!strict_timing_mode_set |=> $stable(strict_timing_mode))
		else $error("mode changed without a set");
	take_gate_a: assert property (downlink_config_ready |-> subframe_trigger ##1 encoder_cfg_strobe)
		else $error("ready off trigger");
endmodule
bind subframe_dynamic_config_handler sdch_chk u_chk (.*);
`default_nettype wire

// >>> verif/host_model.sv
// Purpose: host side of both queues, answering a notice it takes after a set latency unless skip is set or a later take restarts the count
// Assumes: the bench sets lat, skip and the stall input st
// Notes: an answer still counting when the next notice is taken without skip is dropped; a waiting answer is replaced
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench controls
	input wire logic skip,
	input wire logic st,
	input wire logic [4:0] lat,
	// Timing notice queue
	input wire logic nv,
	output logic nr,
	// Configuration queue
	input wire logic cr,
	output logic cv,
	output logic [63:0] cd
);
	int n;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) {nr, cv, cd, n} <= '0;
		else begin
			// A stalled host leaves the notice untaken
			nr <= nv && !nr && !st;
			if (nv && nr && !skip) n <= lat + 1;
			else if (n != 0) n <= n - 1;
			if (n == 1) {cv, cd} <= {1'b1, cd + 64'h9E3779B97F4A7C15};
			else if (cv && cr) {cv, cd} <= {1'b0, ~cd};
		end
	end
endmodule
`default_nettype wire

// >>> verif/subframe_dynamic_config_handler_bench.sv
// Purpose: random triggers against a host model; encoder, notice and mode results checked
// Assumes: 100 MHz clock; four to eleven cycles between triggers
// Notes: a stalled host leaves a notice untaken, so the next trigger overflows it
`timescale 1ns/1ps
`default_nettype none
module subframe_dynamic_config_handler_bench;
	logic clk, arst_n, set, val, trig, skip, st, sp, nv, nr, cv, cr, stb, mo, ovf, md;
	logic [4:0] lat;
	logic [63:0] cd, hd;
	logic [sdch_pkg::SUBFRAME_W-1:0] esf;
	logic [sdch_pkg::FRAME_W-1:0] efr;
	logic [65:0] q[$];
	sdch_pkg::timing_notice_t qn[$];
	logic qo[$];
	logic qm[$];
	sdch_pkg::timing_notice_t nd;
	sdch_pkg::encoder_cfg_t enc;
	int n_mismatch = 0, checks_done = 0, seed = 35342, r;
	subframe_dynamic_config_handler uut (.clk, .arst_n, .strict_timing_mode_set(set),
		.strict_timing_mode_val(val), .subframe_trigger(trig), .timing_notice_data(nd),
		.timing_notice_valid(nv), .timing_notice_ready(nr), .timing_notice_overflow(ovf),
		.downlink_config_data(cd), .downlink_config_valid(cv), .downlink_config_ready(cr),
		.encoder_cfg(enc), .encoder_cfg_strobe(stb), .strict_timing_mode(md));
	host_model host (.clk(clk), .arst_n(arst_n), .skip(skip), .st(st), .lat(lat), .nv(nv),
		.nr(nr), .cr(cr), .cv(cv), .cd(cd));
	task automatic cmp_cfg(input logic [65:0] e, input logic [65:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD encoder_cfg expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_notice(input logic [13:0] e, input logic [13:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD timing_notice_data expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_ovf(input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD timing_notice_overflow expected %b seen %b", e, g);
		end
	endtask
	task automatic cmp_mode(input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD strict_timing_mode expected %b seen %b", e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial #100000 begin
		n_mismatch++;
		tally_and_finish();
	end
	// Strobe, notice and overflow all settle on the edge that launches the strobe; mode settles some cycles earlier
	always @(posedge clk) begin
		if (stb === 1'b1) begin
			cmp_cfg(q.pop_front(), enc);
			cmp_notice(qn.pop_front(), nd);
			cmp_ovf(qo.pop_front(), ovf);
			cmp_mode(qm.pop_front(), md);
		end
	end
	initial begin
		{arst_n, set, val, trig, skip, st, sp, lat, mo, esf, efr} = '0;
		hd = sdch_pkg::EMPTY_CFG;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (80) begin
			@(posedge clk);
			r = $random(seed);
			{set, val, lat, skip} <= {r[0], r[1], r[6:2], &r[8:7]};
			if (r[0]) mo = r[1];
			repeat (2 + r[11:9]) @(posedge clk) set <= 1'b0;
			trig <= 1'b1;
			st <= r[12];
			#1;
			q.push_back(cv ? {2'b10, cd} : mo ? {2'b00, sdch_pkg::EMPTY_CFG} : {2'b11, hd});
			if (cv) hd = cd;
			if (esf == sdch_pkg::LAST_SUBFRAME) begin
				esf = '0;
				efr = efr + 1'b1;
			end else begin
				esf = esf + 1'b1;
			end
			qn.push_back({efr, esf});
			// A notice left by a stalled host is overwritten at this trigger
			qo.push_back(sp);
			sp = r[12];
			qm.push_back(mo);
			@(posedge clk) trig <= 1'b0;
		end
		repeat (9) @(posedge clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
